/* File: hw/src_ctrl.sv */
/*
  serial rom controller: registers, serial engine, config loader.
  assumes strobes from a clk-domain master; pins sampled via src_sync.
*/
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module src_ctrl
  import src_pkg::*;
#(
  parameter int TMO_CYCLES = TMO_CYC,
  parameter int HALF = HALF_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic soft_reset_request,
  input wire logic digital_reset_request,
  input wire logic rom_mode_i2c,
  input wire logic rom_serial_data_in,
  output logic rom_cs,
  output logic rom_sck,
  output logic rom_do,
  output logic rom_di_pulldown_en,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_b,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_b,
  output logic controller_busy_flag,
  output logic [7:0] cfg_byte,
  output logic cfg_strobe,
  output logic irq
);
  typedef enum logic [2:0] {E_IDLE, E_START, E_BITS, E_RSTART, E_STOP, E_END, E_WAIT}
    src_eng_type;
  typedef enum logic [1:0] {LD_IDLE, LD_ISSUE, LD_WAIT} src_ld_type;
  typedef enum logic [1:0] {LP_SIG, LP_LEN, LP_BODY} src_part_type;

  logic [3:0] pins_s;
  logic i2c;
  logic di_s;
  logic scl_s;
  logic sda_s;
  src_eng_type st_ff;
  logic phase_ff;
  logic [7:0] div_ff;
  logic tick;
  logic stretch;
  logic [63:0] tx_ff;
  logic [5:0] slot_ff;
  logic [5:0] nslot_ff;
  logic [3:0] bib_ff;
  logic frb_ff;
  logic [7:0] rx_ff;
  src_req_type op_ff;
  logic eng_done_ff;
  logic eng_err_ff;
  logic eng_fin;
  logic tmo_run;
  logic tmo_exp;
  logic eng_go;
  src_req_type eng_req;
  logic rd_slot;
  logic ack_slot;
  logic din;
  logic waits;
  logic abort;
  logic wr_cmd;
  logic start_bit;
  logic [2:0] code_w;
  logic unsup;
  logic sw_go;
  logic reload;
  logic restart_ld;
  logic kick_ff;
  logic sw_act_ff;
  src_ld_type ld_st_ff;
  src_part_type ld_part_ff;
  logic [15:0] ld_addr_ff;
  logic [7:0] ld_left_ff;
  logic ld_ok_ff;
  logic ld_ovf_ff;
  logic ld_issue;
  logic busy;
  logic [2:0] code_ff;
  logic [15:0] addr_ff;
  logic [7:0] data_ff;
  logic loaded_ff;
  logic ovf_ff;
  logic tmo_ff;
  logic tmo_set;
  logic [EV_W-1:0] ev_ff;
  logic [EV_W-1:0] mask_ff;
  logic [EV_W-1:0] ev_set;
  logic [31:0] rdata_ff;
  logic cs_ff;
  logic sck_ff;
  logic do_ff;
  logic pd_ff;
  logic scl_oe_b_ff;
  logic sda_oe_b_ff;
  logic low_ff;
  logic busy_ff;
  logic [7:0] cfg_byte_ff;
  logic cfg_strobe_ff;
  logic irq_ff;

  // pins from outside the clock domain
  src_sync #(.W(4)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({rom_mode_i2c, rom_serial_data_in, scl_in, sda_in}),
    .q(pins_s)
  );
  assign i2c = pins_s[3];
  assign di_s = pins_s[2];
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // timer runs while waiting on the rom
  assign stretch = i2c && phase_ff && !scl_s && (st_ff == E_BITS || st_ff == E_STOP);
  assign tmo_run = (st_ff == E_WAIT) || stretch;
  src_tmo #(.LIMIT(TMO_CYCLES)) u_tmo (
    .clk(clk),
    .rst_b(rst_b),
    .run(tmo_run),
    .expire(tmo_exp)
  );

  // three-wire header: start bit, opcode, address or sub-opcode
  function automatic logic [MW_HDR-1:0] mw_hdr(input logic [2:0] c, input logic [7:0] a);
    case (c)
      CMD_WRITE: mw_hdr = {3'h5, a};
      CMD_ERASE: mw_hdr = {3'h7, a};
      CMD_WDIS: mw_hdr = {3'h4, 8'h00};
      CMD_WEN: mw_hdr = {3'h4, 8'hc0};
      CMD_ERALL: mw_hdr = {3'h4, 8'h80};
      CMD_WRALL: mw_hdr = {3'h4, 8'h40};
      default: mw_hdr = {3'h6, a};
    endcase
  endfunction

  // half-bit enable; held while the rom stretches the clock
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      div_ff <= 8'h0;
    else if (st_ff == E_IDLE || tick || stretch)
      div_ff <= 8'h0;
    else
      div_ff <= div_ff + 8'h1;
  end
  assign tick = (div_ff == 8'(HALF - 1)) && !stretch;

  assign rd_slot = i2c ? (frb_ff && slot_ff >= 6'd9 && slot_ff <= 6'd16)
                       : (op_ff.code == CMD_READ && slot_ff >= 6'(MW_HDR));
  assign ack_slot = i2c && bib_ff == 4'd8 && !(frb_ff && slot_ff == 6'd17);
  assign din = i2c ? sda_s : di_s;
  assign waits = op_ff.code == CMD_WRITE || op_ff.code == CMD_WRALL ||
                 op_ff.code == CMD_ERASE || op_ff.code == CMD_ERALL;
  assign abort = soft_reset_request || digital_reset_request;

  // serial engine
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff <= E_IDLE;
      phase_ff <= 1'b0;
      tx_ff <= 64'h0;
      slot_ff <= 6'h0;
      nslot_ff <= 6'h0;
      bib_ff <= 4'h0;
      frb_ff <= 1'b0;
      rx_ff <= 8'h0;
      op_ff <= '0;
      eng_done_ff <= 1'b0;
      eng_err_ff <= 1'b0;
    end
    else
    begin
      eng_done_ff <= 1'b0;
      eng_err_ff <= 1'b0;
      if (abort)
        st_ff <= E_IDLE;
      else if (tmo_exp && st_ff != E_IDLE)
      begin
        st_ff <= E_IDLE;
        eng_err_ff <= 1'b1;
      end
      else
        case (st_ff)
          E_IDLE:
            if (eng_go)
            begin
              op_ff <= eng_req;
              st_ff <= E_START;
              phase_ff <= 1'b0;
              slot_ff <= 6'h0;
              bib_ff <= 4'h0;
              frb_ff <= 1'b0;
              if (i2c)
              begin
                tx_ff <= {I2C_DEV, 1'b0, 1'b1, eng_req.addr[15:8], 1'b1,
                          eng_req.addr[7:0], 1'b1, eng_req.data, 1'b1, 28'hfffffff};
                nslot_ff <= (eng_req.code == CMD_WRITE) ? 6'd36 : 6'(I2C_SLOTS_A);
              end
              else
              begin
                tx_ff <= {mw_hdr(eng_req.code, eng_req.addr[7:0]), eng_req.data, 45'h0};
                nslot_ff <= (eng_req.code == CMD_WRITE || eng_req.code == CMD_WRALL ||
                             eng_req.code == CMD_READ) ? 6'd19 : 6'(MW_HDR);
              end
            end
          E_START:
            if (tick)
            begin
              phase_ff <= i2c && !phase_ff;
              if (!i2c || phase_ff)
                st_ff <= E_BITS;
            end
          E_BITS:
            if (tick)
            begin
              phase_ff <= !phase_ff;
              if (phase_ff)
              begin
                tx_ff <= {tx_ff[62:0], 1'b1};
                slot_ff <= slot_ff + 6'h1;
                bib_ff <= (bib_ff == 4'd8) ? 4'h0 : bib_ff + 4'h1;
                if (rd_slot)
                  rx_ff <= {rx_ff[6:0], din};
                if (ack_slot && sda_s)
                begin
                  st_ff <= E_IDLE;
                  eng_err_ff <= 1'b1;
                end
                else if (slot_ff == nslot_ff - 6'h1)
                  st_ff <= (i2c && op_ff.code == CMD_READ && !frb_ff) ? E_RSTART : E_STOP;
              end
            end
          E_RSTART:
            if (tick)
            begin
              phase_ff <= !phase_ff;
              if (phase_ff)
              begin
                st_ff <= E_START;
                frb_ff <= 1'b1;
                slot_ff <= 6'h0;
                bib_ff <= 4'h0;
                nslot_ff <= 6'(I2C_SLOTS_B);
                tx_ff <= {I2C_DEV, 1'b1, {56{1'b1}}};
              end
            end
          E_STOP:
            if (tick)
            begin
              phase_ff <= i2c && !phase_ff;
              if (i2c && phase_ff)
                st_ff <= E_END;
              else if (!i2c && waits)
                st_ff <= E_WAIT;
              else if (!i2c)
              begin
                st_ff <= E_IDLE;
                eng_done_ff <= 1'b1;
              end
            end
          E_END:
            if (tick)
            begin
              st_ff <= E_IDLE;
              eng_done_ff <= 1'b1;
            end
          E_WAIT:
            if (di_s)
            begin
              st_ff <= E_IDLE;
              eng_done_ff <= 1'b1;
            end
          default:
            st_ff <= E_IDLE;
        endcase
    end
  end
  assign eng_fin = eng_done_ff || eng_err_ff;

  // pin drivers; open-drain enables are low while pulling low
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cs_ff <= 1'b0;
      sck_ff <= 1'b0;
      do_ff <= 1'b0;
      pd_ff <= 1'b0;
      scl_oe_b_ff <= 1'b1;
      sda_oe_b_ff <= 1'b1;
      low_ff <= 1'b0;
    end
    else
    begin
      cs_ff <= !i2c && (st_ff == E_START || st_ff == E_BITS || st_ff == E_WAIT);
      sck_ff <= !i2c && st_ff == E_BITS && phase_ff;
      do_ff <= !i2c && st_ff == E_BITS && tx_ff[63];
      pd_ff <= !i2c;
      scl_oe_b_ff <= !(i2c && !phase_ff &&
                       (st_ff == E_BITS || st_ff == E_RSTART || st_ff == E_STOP));
      sda_oe_b_ff <= !(i2c && ((st_ff == E_START && phase_ff) ||
                       (st_ff == E_BITS && !tx_ff[63]) || st_ff == E_STOP));
    end
  end

  // command decode
  assign wr_cmd = reg_wr && reg_addr == CMD_OFS;
  assign code_w = reg_wdata[CODE_LSB+2:CODE_LSB];
  assign busy = sw_act_ff || ld_st_ff != LD_IDLE;
  assign start_bit = wr_cmd && reg_wdata[BUSY_BIT] && !busy;
  assign unsup = i2c && !(code_w == CMD_READ || code_w == CMD_WRITE ||
                          code_w == CMD_RELOAD);
  assign reload = start_bit && code_w == CMD_RELOAD;
  assign sw_go = start_bit && !reload && !unsup;
  assign restart_ld = reload || abort || kick_ff;
  assign ld_issue = ld_st_ff == LD_ISSUE && st_ff == E_IDLE && ld_addr_ff <= ROM_LAST;
  assign eng_go = sw_go || ld_issue;
  assign eng_req = ld_issue ? {CMD_READ, ld_addr_ff, 8'h00} : {code_w, reg_wdata[15:0], data_ff};

  // command activity; loader kick after reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      kick_ff <= 1'b1;
      sw_act_ff <= 1'b0;
    end
    else
    begin
      kick_ff <= 1'b0;
      if (sw_go)
        sw_act_ff <= 1'b1;
      else if (eng_fin || abort)
        sw_act_ff <= 1'b0;
    end
  end

  // config loader: signature, length, then body bytes
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ld_st_ff <= LD_IDLE;
      ld_part_ff <= LP_SIG;
      ld_addr_ff <= 16'h0;
      ld_left_ff <= 8'h0;
      ld_ok_ff <= 1'b0;
      ld_ovf_ff <= 1'b0;
      cfg_byte_ff <= 8'h0;
      cfg_strobe_ff <= 1'b0;
    end
    else
    begin
      ld_ok_ff <= 1'b0;
      ld_ovf_ff <= 1'b0;
      cfg_strobe_ff <= 1'b0;
      if (restart_ld)
      begin
        ld_st_ff <= LD_ISSUE;
        ld_part_ff <= LP_SIG;
        ld_addr_ff <= 16'h0;
      end
      else
        case (ld_st_ff)
          LD_ISSUE:
            if (ld_addr_ff > ROM_LAST)
            begin
              ld_st_ff <= LD_IDLE;
              ld_ovf_ff <= 1'b1;
            end
            else if (ld_issue)
              ld_st_ff <= LD_WAIT;
          LD_WAIT:
            if (eng_err_ff)
              ld_st_ff <= LD_IDLE;
            else if (eng_done_ff)
            begin
              ld_st_ff <= LD_ISSUE;
              ld_addr_ff <= ld_addr_ff + 16'h1;
              case (ld_part_ff)
                LP_SIG:
                  if (rx_ff == ROM_SIG)
                    ld_part_ff <= LP_LEN;
                  else
                    ld_st_ff <= LD_IDLE;
                LP_LEN:
                begin
                  ld_left_ff <= rx_ff;
                  ld_part_ff <= LP_BODY;
                  if (rx_ff == 8'h0)
                  begin
                    ld_st_ff <= LD_IDLE;
                    ld_ok_ff <= 1'b1;
                  end
                end
                default:
                begin
                  cfg_byte_ff <= rx_ff;
                  cfg_strobe_ff <= 1'b1;
                  ld_left_ff <= ld_left_ff - 8'h1;
                  if (ld_left_ff == 8'h1)
                  begin
                    ld_st_ff <= LD_IDLE;
                    ld_ok_ff <= 1'b1;
                  end
                end
              endcase
            end
          default:
            ld_st_ff <= LD_IDLE;
        endcase
    end
  end

  // address, code and data fields; locked while busy
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      code_ff <= 3'h0;
      addr_ff <= 16'h0;
      data_ff <= 8'h0;
    end
    else
    begin
      if (wr_cmd && !busy)
      begin
        code_ff <= code_w;
        addr_ff <= reg_wdata[15:0];
      end
      if (reg_wr && reg_addr == DATA_OFS && !busy)
        data_ff <= reg_wdata[7:0];
      else if (eng_done_ff && sw_act_ff && op_ff.code == CMD_READ)
        data_ff <= rx_ff;
    end
  end

  // status flags; hardware set wins over a write-one clear
  assign tmo_set = eng_err_ff || (start_bit && unsup);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      loaded_ff <= 1'b0;
      ovf_ff <= 1'b0;
      tmo_ff <= 1'b0;
    end
    else
    begin
      if (restart_ld)
        loaded_ff <= 1'b0;
      else if (ld_ok_ff)
        loaded_ff <= 1'b1;
      else if (wr_cmd && reg_wdata[LOADED_BIT])
        loaded_ff <= 1'b0;
      if (restart_ld)
        ovf_ff <= 1'b0;
      else if (ld_ovf_ff)
        ovf_ff <= 1'b1;
      if (tmo_set)
        tmo_ff <= 1'b1;
      else if (wr_cmd && reg_wdata[TMO_BIT])
        tmo_ff <= 1'b0;
    end
  end

  // interrupt status and mask
  always_comb
  begin
    ev_set = '0;
    ev_set[EV_DONE] = eng_fin && sw_act_ff;
    ev_set[EV_TMO] = tmo_set;
    ev_set[EV_LOAD] = ld_ok_ff;
    ev_set[EV_OVF] = ld_ovf_ff;
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ev_ff <= '0;
      mask_ff <= '0;
      irq_ff <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == ISTAT_OFS)
        ev_ff <= (ev_ff & ~reg_wdata[EV_W-1:0]) | ev_set;
      else
        ev_ff <= ev_ff | ev_set;
      if (reg_wr && reg_addr == IMASK_OFS)
        mask_ff <= reg_wdata[EV_W-1:0];
      irq_ff <= |(ev_ff & mask_ff);
    end
  end

  // read port: data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_ff <= 32'h0;
    else if (!reg_rd)
      rdata_ff <= 32'h0;
    else
      case (reg_addr)
        CMD_OFS: rdata_ff <= {busy, code_ff, 9'h0, ovf_ff, tmo_ff, loaded_ff, addr_ff};
        DATA_OFS: rdata_ff <= {24'h0, data_ff};
        ISTAT_OFS: rdata_ff <= {28'h0, ev_ff};
        IMASK_OFS: rdata_ff <= {28'h0, mask_ff};
        MODE_OFS: rdata_ff <= {31'h0, i2c};
        default: rdata_ff <= 32'h0;
      endcase
  end

  // busy flag to the rest of the controller
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      busy_ff <= 1'b0;
    else
      busy_ff <= busy;
  end

  assign reg_rdata = rdata_ff;
  assign rom_cs = cs_ff;
  assign rom_sck = sck_ff;
  assign rom_do = do_ff;
  assign rom_di_pulldown_en = pd_ff;
  assign scl_out = low_ff;
  assign scl_oe_b = scl_oe_b_ff;
  assign sda_out = low_ff;
  assign sda_oe_b = sda_oe_b_ff;
  assign controller_busy_flag = busy_ff;
  assign cfg_byte = cfg_byte_ff;
  assign cfg_strobe = cfg_strobe_ff;
  assign irq = irq_ff;
endmodule // src_ctrl

/* File: hw/src_sync.sv */
/*
  two-flop synchroniser for a group of pins.
  assumes the inputs are asynchronous to clk.
*/
`timescale 1ns/1ps
module src_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_ff <= '0;
      q_ff <= '0;
    end
    else
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule // src_sync

/* File: hw/src_tmo.sv */
/*
  response timeout counter.
  assumes run is a level from clk logic; dropping run restarts the count.
*/
`timescale 1ns/1ps
module src_tmo #(
  parameter int LIMIT = 6000000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  output logic expire
);
  logic [31:0] cnt_ff;
  logic expire_ff;

  // count while waiting, restart at every new wait
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_ff <= 32'h0;
      expire_ff <= 1'b0;
    end
    else
    begin
      expire_ff <= run && (cnt_ff == 32'(LIMIT - 1));
      if (!run || cnt_ff == 32'(LIMIT - 1))
        cnt_ff <= 32'h0;
      else
        cnt_ff <= cnt_ff + 32'h1;
    end
  end
  assign expire = expire_ff;
endmodule // src_tmo

/* File: pkg/src_pkg.sv */
/*
  constants, field layout and carrier types of the serial rom controller.
  assumes one 200 mhz clock and a byte-addressed register port.
*/
// Function
// - loader reading past rom end sets overflow
// - overflow read-only, cleared only on loader restart
// - erase/write kinds time out after 30 ms
// - i2c: missing ack, stretch, bad code time out
// - timeout and loaded flags clear on written one
// - three-wire mode enables data-in pull-down
// - only erase/write kinds wait for rom ready
// - successful load sets configuration-loaded flag
// - loaded flag cleared on resets and reload start
// - 16-bit rom address field, reset zero
// - 8-bit data field, upper bits read zero
package src_pkg;
  // timing
  localparam int CLK_NS = 5;
  localparam int CLK_MHZ = 1000 / CLK_NS;
  localparam int TMO_MS = 30;
  localparam int TMO_CYC = TMO_MS * CLK_MHZ * 1000;
  localparam int HALF_NS = 80;
  localparam int HALF_CYC = HALF_NS / CLK_NS;
  // register byte offsets
  localparam logic [11:0] CMD_OFS = 12'h1b4;
  localparam logic [11:0] DATA_OFS = 12'h1b8;
  localparam logic [11:0] ISTAT_OFS = 12'h1bc;
  localparam logic [11:0] IMASK_OFS = 12'h1c0;
  localparam logic [11:0] MODE_OFS = 12'h1c4;
  // command register fields
  localparam int BUSY_BIT = 31;
  localparam int CODE_LSB = 28;
  localparam int OVF_BIT = 18;
  localparam int TMO_BIT = 17;
  localparam int LOADED_BIT = 16;
  // event bits
  localparam int EV_W = 4;
  localparam int EV_DONE = 0;
  localparam int EV_TMO = 1;
  localparam int EV_LOAD = 2;
  localparam int EV_OVF = 3;
  // command codes
  localparam logic [2:0] CMD_READ = 3'h0;
  localparam logic [2:0] CMD_WDIS = 3'h1;
  localparam logic [2:0] CMD_WEN = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h3;
  localparam logic [2:0] CMD_WRALL = 3'h4;
  localparam logic [2:0] CMD_ERASE = 3'h5;
  localparam logic [2:0] CMD_ERALL = 3'h6;
  localparam logic [2:0] CMD_RELOAD = 3'h7;
  // rom layout
  localparam logic [7:0] ROM_SIG = 8'ha5;
  localparam logic [15:0] ROM_LAST = 16'h00ff;
  localparam logic [6:0] I2C_DEV = 7'h50;
  localparam int MW_HDR = 11;
  localparam int I2C_SLOTS_A = 27;
  localparam int I2C_SLOTS_B = 18;

  typedef struct packed {
    logic [2:0] code;
    logic [15:0] addr;
    logic [7:0] data;
  } src_req_type;
endpackage

/* File: tb/src_checker.sv */
/*
  port assertions of the serial rom controller.
  assumes one clock; the mode pin moves only between commands.
*/
`timescale 1ns/1ps
module src_checker
  import src_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic rom_mode_i2c,
  input wire logic rom_cs,
  input wire logic rom_di_pulldown_en,
  input wire logic scl_out,
  input wire logic scl_oe_b,
  input wire logic sda_out,
  input wire logic sda_oe_b,
  input wire logic controller_busy_flag,
  input wire logic cfg_strobe,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // steps before a command start
  sequence s_wire3; (!rom_mode_i2c) [*5]; endsequence
  sequence s_i2c; rom_mode_i2c [*5]; endsequence
  sequence s_idle; (!controller_busy_flag) [*3]; endsequence
  sequence s_start;
    reg_wr && reg_addr == CMD_OFS && reg_wdata[31] && reg_wdata[30:28] == CMD_READ;
  endsequence

  AST_RDATA_IDLE:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  AST_DATA_UPPER:
    assert property ($past(reg_rd) && $past(reg_addr) == DATA_OFS |-> reg_rdata[31:8] == 24'h0)
    else $error("data upper bits set");
  AST_PULLDOWN_ON:
    assert property (s_wire3 |=> rom_di_pulldown_en)
    else $error("pull-down off");
  AST_PULLDOWN_OFF:
    assert property (s_i2c |=> !rom_di_pulldown_en)
    else $error("pull-down on");
  AST_I2C_RELEASED:
    assert property (s_wire3 |=> scl_oe_b && sda_oe_b)
    else $error("i2c line pulled");
  AST_I2C_LOW_ONLY:
    assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("i2c level not low");
  AST_CS_IN_CMD:
    assert property ($rose(rom_cs) |-> ##[0:2] controller_busy_flag)
    else $error("chip select without busy");
  AST_STROBE_PULSE:
    assert property (cfg_strobe |=> !cfg_strobe)
    else $error("long config strobe");
  AST_IRQ_MASKED:
    assert property (reg_wr && reg_addr == IMASK_OFS && reg_wdata[3:0] == 4'h0 |-> ##2 !irq)
    else $error("irq while all masked");
  AST_BUSY_START:
    assert property ((s_wire3 and s_idle) ##0 s_start |-> ##[1:4] controller_busy_flag)
    else $error("read not started");
endmodule // src_checker

bind src_ctrl src_checker chk (.*);

/* File: tb/src_rom_model.sv */
/*
  behavioural three-wire serial rom: header in, data both ways, ready poll.
  assumes kind 0 present, 1 absent, 2 absent with data-in pulled high.
*/
`timescale 1ns/1ps
module src_rom_model
(
  input wire logic rom_cs,
  input wire logic rom_sck,
  input wire logic rom_do,
  input wire logic pulldown_en,
  input wire logic [1:0] kind,
  output logic rom_serial_data_in
);
  logic [7:0] mem [0:255];
  logic [10:0] hdr;
  logic [7:0] sh;
  logic drv = 1'b0;
  logic val = 1'b0;
  int bits;
  // released line: pull level, else inverse
  assign rom_serial_data_in = (kind == 2'h2) ? 1'b1 :
    (drv && kind == 2'h0) ? val : (pulldown_en ? 1'b0 : ~val);
  // a select with no clock after it is a ready poll
  always @(posedge rom_cs)
  begin
    bits = 0;
    drv = 1'b0;
    #300;
    if (rom_cs && bits == 0)
    begin
      val = 1'b1;
      drv = 1'b1;
    end
  end
  always @(negedge rom_cs) drv = 1'b0;
  // header, then data both ways
  always @(posedge rom_sck)
    if (rom_cs)
    begin
      bits++;
      if (bits <= 11)
        hdr = {hdr[9:0], rom_do};
      else if (bits <= 19)
      begin
        sh = {sh[6:0], rom_do};
        val = mem[hdr[7:0]][19 - bits];
        drv = 1'b1;
      end
    end
endmodule // src_rom_model

/* File: tb/test_src_ctrl.sv */
/*
  bench for src_ctrl: register tasks, rom model on three-wire pins.
  assumes short timeout and half-bit; i2c lines pulled up.
*/
`timescale 1ns/1ps
module test_src_ctrl
  import src_pkg::*;
;
  localparam int TMO = 200;
  logic clk, rst_b, reg_wr, reg_rd, soft_rq, dig_rq, mode_i2c, di, cs, sck, dout, pd;
  logic scl_oe_b, sda_oe_b, busy, strb, irq;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [7:0] cfg_byte, cfg_last;
  logic [1:0] kind;
  int failures, samples_checked, strobes, span;
  src_rom_model rom (.rom_cs(cs), .rom_sck(sck), .rom_do(dout), .pulldown_en(pd),
    .kind(kind), .rom_serial_data_in(di));
  // pulled-up i2c wires
  src_ctrl #(.TMO_CYCLES(TMO), .HALF(4)) dut (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .soft_reset_request(soft_rq), .digital_reset_request(dig_rq),
    .rom_mode_i2c(mode_i2c), .rom_serial_data_in(di), .rom_cs(cs), .rom_sck(sck),
    .rom_do(dout), .rom_di_pulldown_en(pd), .scl_in(scl_oe_b), .scl_out(),
    .scl_oe_b(scl_oe_b), .sda_in(sda_oe_b), .sda_out(), .sda_oe_b(sda_oe_b),
    .controller_busy_flag(busy), .cfg_byte(cfg_byte), .cfg_strobe(strb), .irq(irq));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // loader byte counter
  always @(posedge clk)
    if (strb === 1'b1)
    begin
      strobes++;
      cfg_last <= cfg_byte;
    end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // data stands one cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // bounded idle wait, then status read
  task automatic idle();
    span = 0;
    repeat (3) @(posedge clk);
    while (busy !== 1'b0 && span < 60000)
    begin
      @(posedge clk);
      span++;
    end
    if (span >= 60000) failures++;
    rd(CMD_OFS, v);
  endtask
  task automatic run(input logic [2:0] c, input logic [15:0] a);
    wr(CMD_OFS, {1'b1, c, 12'h0, a});
    idle();
  endtask
  task automatic pulse(input logic d);
    @(posedge clk);
    dig_rq <= d;
    soft_rq <= ~d;
    @(posedge clk);
    dig_rq <= 1'b0;
    soft_rq <= 1'b0;
    idle();
  endtask
  task automatic print_verdict();
    $display("counts: %0d checked, %0d wrong", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {rst_b, reg_wr, reg_rd, soft_rq, dig_rq, mode_i2c} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    kind = 2'h0;
    for (int i = 0; i < 256; i++) rom.mem[i] = 8'(i * 3 + 1);
    rom.mem[0] = ROM_SIG;
    rom.mem[1] = 8'h02;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    idle();
    chk("loaded", 32'h1, {31'h0, v[16]});
    chk("overflow", 32'h0, {31'h0, v[18]});
    chk("address", 32'h0, {16'h0, v[15:0]});
    chk("bytes", 32'h2, 32'(strobes));
    chk("last byte", {24'h0, rom.mem[3]}, {24'h0, cfg_last});
    rd(DATA_OFS, v);
    chk("data reset", 32'h0, v);
    wr(CMD_OFS, 32'h0);
    rd(CMD_OFS, v);
    chk("loaded kept", 32'h1, {31'h0, v[16]});
    wr(CMD_OFS, 32'h0001_0000);
    rd(CMD_OFS, v);
    chk("loaded cleared", 32'h0, {31'h0, v[16]});
    $display("test load and flags done");
    run(CMD_READ, 16'h0005);
    rd(DATA_OFS, v);
    chk("read byte", {24'h0, rom.mem[5]}, v);
    chk("rom address", 32'h5, {24'h0, rom.hdr[7:0]});
    wr(DATA_OFS, 32'hffff_ff5a);
    rd(DATA_OFS, v);
    chk("data field", 32'h5a, v);
    run(CMD_WRITE, 16'h0009);
    chk("written byte", 32'h5a, {24'h0, rom.sh});
    chk("write ok", 32'h0, {31'h0, v[17]});
    kind = 2'h1;
    for (int c = 0; c < 7; c++)
    begin
      run(3'(c), 16'h0);
      chk("timeout by code", {31'h0, c >= 3}, {31'h0, v[17]});
      chk("wait span", {31'h0, c >= 3}, {31'h0, span >= TMO && span < TMO + 250});
      wr(CMD_OFS, 32'h0002_0000);
    end
    kind = 2'h2;
    run(CMD_ERASE, 16'h0);
    chk("pulled high", 32'h0, {31'h0, v[17]});
    $display("test three-wire commands done");
    kind = 2'h1;
    wr(ISTAT_OFS, 32'hf);
    wr(IMASK_OFS, 32'h2);
    run(CMD_ERALL, 16'h0);
    chk("irq set", 32'h1, {31'h0, irq});
    wr(ISTAT_OFS, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    wr(IMASK_OFS, 32'h0);
    wr(CMD_OFS, 32'h0002_0000);
    rd(12'h000, v);
    chk("unmapped", 32'h0, v);
    mode_i2c <= 1'b1;
    repeat (8) @(posedge clk);
    chk("pulldown off", 32'h0, {31'h0, pd});
    for (int c = 0; c < 7; c++)
    begin
      run(3'(c), 16'h0);
      chk("i2c timeout", 32'h1, {31'h0, v[17]});
      wr(CMD_OFS, 32'h0002_0000);
    end
    mode_i2c <= 1'b0;
    repeat (8) @(posedge clk);
    $display("test irq and i2c done");
    kind = 2'h0;
    pulse(1'b0);
    chk("soft reload", 32'h1, {31'h0, v[16]});
    rom.mem[1] = 8'hff;
    wr(CMD_OFS, {1'b1, CMD_RELOAD, 28'h0});
    repeat (2) @(posedge clk);
    rd(CMD_OFS, v);
    chk("loaded at restart", 32'h0, {31'h0, v[16]});
    idle();
    chk("overflow set", 32'h1, {31'h0, v[18]});
    wr(CMD_OFS, 32'h0004_0000);
    rd(CMD_OFS, v);
    chk("overflow kept", 32'h1, {31'h0, v[18]});
    rom.mem[1] = 8'h02;
    pulse(1'b1);
    chk("overflow gone", 32'h0, {31'h0, v[18]});
    chk("reloaded", 32'h1, {31'h0, v[16]});
    $display("test reload done");
    print_verdict();
  end
  // hang guard; a run is about 50k cycles
  initial
  begin
    #400_000;
    failures++;
    print_verdict();
  end
endmodule // test_src_ctrl
